/* hdl/esie_edge_det.sv */
/*
  Synchronises asynchronous pins and flags the selected edge.
  Assumes pins are asynchronous to clock_in; polarity from same clock.
*/
`timescale 1ns/10ps
module esie_edge_det #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] pin_in,       // Raw pins
  input  wire logic [WIDTH-1:0] rising_in,    // 1 rising, 0 falling
  output logic      [WIDTH-1:0] edge_out      // One-cycle edge pulse
);
  logic [WIDTH-1:0] meta_r;   // First stage, read only by sync_r
  logic [WIDTH-1:0] sync_r;   // Second stage
  logic [WIDTH-1:0] last_r;   // Previous synchronised level

  initial begin
    if (WIDTH < 1) $error("esie_edge_det: WIDTH must be positive");
  end

  // Two-flop synchroniser plus history; idle level high (pins active low)
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '1;
      sync_r <= '1;
      last_r <= '1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edge chosen per bit
  always_comb begin
    edge_out = (rising_in & sync_r & ~last_r) | (~rising_in & ~sync_r & last_r);
  end
endmodule : esie_edge_det

/* hdl/esie_pkg.sv */
/*
  Package for the edge select and interrupt enable block: register
  offsets, reset values and field positions.
  Assumes a 32-bit APB with one aligned word per register.
*/
package esie_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REQ_EDGE  = 8'h00; // Request pin edge select
  localparam logic [7:0] OFF_INT_EDGE  = 8'h04; // Interrupt pin edge select
  localparam logic [7:0] OFF_EN1       = 8'h08; // Timer and request enable
  localparam logic [7:0] OFF_EN2       = 8'h0c; // Misc source enable
  localparam logic [7:0] OFF_FLAG1     = 8'h10; // Request flags, set one
  localparam logic [7:0] OFF_FLAG2     = 8'h14; // Misc flags
  localparam logic [7:0] OFF_INT_FLAG  = 8'h18; // Interrupt pin flags
  localparam logic [7:0] OFF_INT_EN    = 8'h1c; // Interrupt pin enables
  localparam logic [7:0] OFF_MODE      = 8'h20; // Pin interrupt mode select
  // Reset values
  localparam logic [7:0] RST_REQ_EDGE  = 8'h70; // Bits 6..4 read one
  localparam logic [7:0] RST_INT_EDGE  = 8'h00;
  localparam logic [7:0] RST_EN1       = 8'h10;
  localparam logic [7:0] RST_EN2       = 8'h00;
  localparam logic [7:0] RST_FLAG1     = 8'h10;
  // Writable masks
  localparam logic [7:0] MSK_REQ_EDGE  = 8'h0f;
  localparam logic [7:0] MSK_EN1       = 8'hcf;
  localparam logic [7:0] MSK_EN2       = 8'hd0;
  localparam logic [7:0] MSK_FLAG1     = 8'hcf;
  // Field positions
  localparam int BIT_TB1  = 7; // Timer B1 overflow
  localparam int BIT_TA   = 6; // Timer A overflow
  localparam int BIT_DT   = 7; // Direct transfer
  localparam int BIT_AD   = 6; // Converter end
  localparam int BIT_S1   = 4; // Serial channel one done
  localparam int BIT_P7   = 7; // Pin 7 with timer Y input
  localparam int BIT_P6   = 6; // Pin 6 with timer B1 input
  localparam int BIT_P5   = 5; // Pin 5 with converter trigger
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage : esie_pkg

/* hdl/esie_top.sv */
/*
  Edge select and interrupt enable registers with request flags.
  Assumes an APB master on clock_in and a CPU core taking the request
  lines; peripheral events arrive as one-cycle pulses on clock_in.
*/
// Chosen here: the register offsets and the APB register port.
// What this block does
// - Bit 2 picks request pin 2 edge
// - Bit 1 picks request pin 1 edge
// - Bit 0 picks request pin 0 edge
// - Interrupt pin edge register resets to zero
// - Bit 7 sets pin 7 and timer Y
// - Bit 6 sets pin 6 and timer B1
// - Bit 5 sets pin 5 and trigger
// - Bits 4..0 set same-index pin edges
// - First enable register resets to 0x10
// - Bit 7 enables timer B1 overflow
// - Bit 6 enables timer A overflow
// - Bits 3..0 enable request pins
// - Bit 4 reads one, bit 5 zero
// - Second enable register resets to zero
// - Bit 7 enables direct transfer request
// - Bit 6 enables converter end request
// - Bit 4 enables serial one done
// - Bits 3..0 of second read zero
// - Flag sets on selected edge, enable or not (request pins only with mode bit on); enables gate only forwarding
// - Flags clear only by writing zero
// - Mask stops presentation, flags still set
`timescale 1ns/10ps
module esie_top #(
  parameter int REQ_PINS = 4,
  parameter int INT_PINS = 8
) (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  input  wire logic [3:0]          pstrb_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Pins, active low, asynchronous
  input  wire logic [REQ_PINS-1:0] external_request_pin_in,
  input  wire logic [INT_PINS-1:0] external_interrupt_pin_in,
  // Peripheral event pulses on clock_in
  input  wire logic                timer_b1_ovf_in,
  input  wire logic                timer_a_ovf_in,
  input  wire logic                direct_transfer_in,
  input  wire logic                converter_end_in,
  input  wire logic                serial_one_done_in,
  // CPU side
  input  wire logic                cpu_imask_in,     // Global mask bit
  // Shared edge polarities for other blocks
  output logic                     timer_y_event_input_rise_out,
  output logic                     timer_b1_event_input_rise_out,
  output logic                     converter_trigger_input_rise_out,
  // Requests to CPU
  output logic [7:0]               irq_grp1_out,  // Layout of first flag reg
  output logic [7:0]               irq_grp2_out,  // Layout of second flag reg
  output logic [INT_PINS-1:0]      irq_int_out,
  output logic                     irq_any_out
);
  initial begin
    if (REQ_PINS != 4) $error("esie_top: REQ_PINS must be 4");
    if (INT_PINS != 8) $error("esie_top: INT_PINS must be 8");
  end

  // Registers
  logic [7:0]          request_pin_edge_select_r; // Request pin edges
  logic [7:0]          int_pin_edge_select_r;     // Interrupt pin edges
  logic [7:0]          timer_and_irq_enable_r;    // First enable
  logic [7:0]          misc_source_enable_r;      // Second enable
  logic [7:0]          flag1_r;                   // Timer and request flags
  logic [7:0]          flag2_r;                   // Misc flags
  logic [INT_PINS-1:0] int_flag_r;                // Interrupt pin flags
  logic [INT_PINS-1:0] int_enable_r;              // Interrupt pin enables
  logic [7:0]          mode_r;                    // Pin interrupt function on
  logic [REQ_PINS-1:0] req_edge;                  // Request pin edge pulses
  logic [INT_PINS-1:0] int_edge;                  // Interrupt pin edge pulses
  logic                wr_en;                     // APB write strobe
  logic [7:0]          wbyte;                     // Low write byte
  logic [7:0]          set1;                      // Set terms, first flags
  logic [7:0]          set2;                      // Set terms, second flags
  logic [INT_PINS-1:0] set3;                      // Set terms, pin flags

  // Address hit test
  // Kept as functions: each offset is decoded in several places
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) && (addr <= esie_pkg::OFF_MODE);
  endfunction : mapped

  // Zero-write clear with set winning over clear
  // Mask keeps reserved and unused positions at zero
  function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic [7:0] wd,
                                          input logic       we,
                                          input logic [7:0] msk);
    logic [7:0] clr;
    clr = we ? (~wd & msk) : 8'h00;
    flag_upd = ((cur & ~clr) | set) & msk;
  endfunction : flag_upd

  // Zero-wait APB: every access completes in its access phase
  // All registers are flops, so no wait state is ever needed
  assign pready_out  = 1'b1;
  assign wr_en = psel_in & penable_in & pwrite_in & pstrb_in[0];
  assign wbyte = pwdata_in[7:0];

  // Unmapped or misaligned addresses answer with an error
  // The write is dropped as well, so a stray address changes nothing
  always_comb begin
    pslverr_out = psel_in & penable_in & ~mapped(paddr_in);
  end

  // Pin edge detectors; request pins and interrupt pins share one array
  // One shared array gives both pin groups the same latency
  esie_edge_det #(
    .WIDTH (REQ_PINS + INT_PINS)
  ) u_edge (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .pin_in    ({external_interrupt_pin_in, external_request_pin_in}),
    .rising_in ({int_pin_edge_select_r[INT_PINS-1:0],
                 request_pin_edge_select_r[REQ_PINS-1:0]}),
    .edge_out  ({int_edge, req_edge})
  );

  // Request pin edge register; bits 6..4 fixed one, bit 7 zero
  // Reserved bits are rebuilt on every write, never taken from the bus
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      request_pin_edge_select_r <= esie_pkg::RST_REQ_EDGE;
    end else if (wr_en && hit(paddr_in, esie_pkg::OFF_REQ_EDGE)) begin
      request_pin_edge_select_r <= (wbyte & esie_pkg::MSK_REQ_EDGE) |
                                   (esie_pkg::RST_REQ_EDGE & ~esie_pkg::MSK_REQ_EDGE);
    end
  end

  // Interrupt pin edge register, fully writable
  // Bits 7..5 also steer the timer and converter input polarities
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_pin_edge_select_r <= esie_pkg::RST_INT_EDGE;
    end else if (wr_en && hit(paddr_in, esie_pkg::OFF_INT_EDGE)) begin
      int_pin_edge_select_r <= wbyte;
    end
  end

  // Shared polarities leave toward timer and converter blocks
  // Taken straight from the register, so no extra flop delay
  assign timer_y_event_input_rise_out     = int_pin_edge_select_r[esie_pkg::BIT_P7];
  assign timer_b1_event_input_rise_out    = int_pin_edge_select_r[esie_pkg::BIT_P6];
  assign converter_trigger_input_rise_out = int_pin_edge_select_r[esie_pkg::BIT_P5];

  // First enable; reserved bit 4 stays one, bit 5 stays zero
  // Forcing bit 4 on each write keeps its read value fixed
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      timer_and_irq_enable_r <= esie_pkg::RST_EN1;
    end else if (wr_en && hit(paddr_in, esie_pkg::OFF_EN1)) begin
      timer_and_irq_enable_r <= (wbyte & esie_pkg::MSK_EN1) | esie_pkg::RST_EN1;
    end
  end

  // Second enable; reserved bits stay zero
  // Unused positions are masked off so they always read back zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      misc_source_enable_r <= esie_pkg::RST_EN2;
    end else if (wr_en && hit(paddr_in, esie_pkg::OFF_EN2)) begin
      misc_source_enable_r <= wbyte & esie_pkg::MSK_EN2;
    end
  end

  // Interrupt pin enables and pin mode register
  // Mode bits gate only the request pins; interrupt pins always flag
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_enable_r <= '0;
      mode_r       <= 8'h00;
    end else if (wr_en) begin
      if (hit(paddr_in, esie_pkg::OFF_INT_EN)) begin
        int_enable_r <= wbyte[INT_PINS-1:0];
      end
      if (hit(paddr_in, esie_pkg::OFF_MODE)) begin
        mode_r <= wbyte & esie_pkg::MSK_REQ_EDGE;
      end
    end
  end

  // Flag set terms; request pins only when configured for interrupt input
  // Events are single-cycle pulses; a longer pulse just sets again
  always_comb begin
    set1 = 8'h00;
    set1[esie_pkg::BIT_TB1] = timer_b1_ovf_in;
    set1[esie_pkg::BIT_TA]  = timer_a_ovf_in;
    set1[REQ_PINS-1:0]      = req_edge & mode_r[REQ_PINS-1:0];
    set2 = 8'h00;
    set2[esie_pkg::BIT_DT]  = direct_transfer_in;
    set2[esie_pkg::BIT_AD]  = converter_end_in;
    set2[esie_pkg::BIT_S1]  = serial_one_done_in;
    set3 = int_edge;
  end

  // Flags: cleared only by writing zero, never on acceptance
  // A set in the cycle of a clearing write wins, so no event is lost
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flag1_r    <= esie_pkg::RST_FLAG1;
      flag2_r    <= 8'h00;
      int_flag_r <= '0;
    end else begin
      flag1_r    <= flag_upd(flag1_r, set1, wbyte,
                             wr_en && hit(paddr_in, esie_pkg::OFF_FLAG1),
                             esie_pkg::MSK_FLAG1) | esie_pkg::RST_FLAG1;
      flag2_r    <= flag_upd(flag2_r, set2, wbyte,
                             wr_en && hit(paddr_in, esie_pkg::OFF_FLAG2),
                             esie_pkg::MSK_EN2);
      int_flag_r <= flag_upd(int_flag_r, set3, wbyte,
                             wr_en && hit(paddr_in, esie_pkg::OFF_INT_FLAG),
                             8'hff);
    end
  end

  // Forward to CPU: flag and enable, held off by the global mask
  // The mask hides requests but never touches the flags underneath
  always_comb begin
    irq_grp1_out = cpu_imask_in ? 8'h00 :
                   (flag1_r & timer_and_irq_enable_r & esie_pkg::MSK_FLAG1);
    irq_grp2_out = cpu_imask_in ? 8'h00 :
                   (flag2_r & misc_source_enable_r);
    irq_int_out  = cpu_imask_in ? '0 : (int_flag_r & int_enable_r);
    irq_any_out  = |{irq_grp1_out, irq_grp2_out, irq_int_out};
  end

  // Read mux; registers already hold their fixed bits
  // Decoded on address alone; the master qualifies it with psel
  always_comb begin
    prdata_out = 32'h0000_0000;
    unique case (paddr_in)
      esie_pkg::OFF_REQ_EDGE: prdata_out[7:0] = request_pin_edge_select_r;
      esie_pkg::OFF_INT_EDGE: prdata_out[7:0] = int_pin_edge_select_r;
      esie_pkg::OFF_EN1:      prdata_out[7:0] = timer_and_irq_enable_r;
      esie_pkg::OFF_EN2:      prdata_out[7:0] = misc_source_enable_r;
      esie_pkg::OFF_FLAG1:    prdata_out[7:0] = flag1_r;
      esie_pkg::OFF_FLAG2:    prdata_out[7:0] = flag2_r;
      esie_pkg::OFF_INT_FLAG: prdata_out[INT_PINS-1:0] = int_flag_r;
      esie_pkg::OFF_INT_EN:   prdata_out[INT_PINS-1:0] = int_enable_r;
      esie_pkg::OFF_MODE:     prdata_out[7:0] = mode_r;
      default:                prdata_out = 32'h0000_0000;
    endcase
  end

  // Checks
  // Reserved bits and write paths first, then flag and request gating; reset values later
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  en1_fixed_a: assert property (timer_and_irq_enable_r[4] && !timer_and_irq_enable_r[5])
    else $error("First enable reserved bits wrong");
  en2_resv_a: assert property ((misc_source_enable_r & ~esie_pkg::MSK_EN2) == 8'h00)
    else $error("Second enable reserved bits set");
  en1_write_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_EN1) |=>
    timer_and_irq_enable_r[7:6] == $past(wbyte[7:6]))
    else $error("Timer enables did not take write");
  en2_write_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_EN2) |=>
    misc_source_enable_r[7:6] == $past(wbyte[7:6]) && misc_source_enable_r[4] == $past(wbyte[4]))
    else $error("Misc enables did not take write");
  flag_hold_a: assert property (flag2_r[esie_pkg::BIT_S1] &&
    !(wr_en && hit(paddr_in, esie_pkg::OFF_FLAG2)) |=> flag2_r[esie_pkg::BIT_S1])
    else $error("Flag cleared without a write");
  set_wins_a: assert property (serial_one_done_in |=> flag2_r[esie_pkg::BIT_S1])
    else $error("Event lost against clear");
  mask_gate_a: assert property (cpu_imask_in |-> !irq_any_out)
    else $error("Request shown while masked");
  fwd_ad_a: assert property (!cpu_imask_in && flag2_r[6] && misc_source_enable_r[6]
    |-> irq_grp2_out[6]) else $error("Converter request not forwarded");
  fwd_gate_a: assert property (!timer_and_irq_enable_r[6] |-> !irq_grp1_out[6])
    else $error("Disabled timer A forwarded");
  pin_flag_a: assert property (req_edge[0] && mode_r[0] |=> flag1_r[0])
    else $error("Request pin flag not set");
  req_fwd_a: assert property (!cpu_imask_in && flag1_r[1] && timer_and_irq_enable_r[1]
    |-> irq_grp1_out[1]) else $error("Request pin not forwarded");
  share_a: assert property (timer_y_event_input_rise_out == int_pin_edge_select_r[7])
    else $error("Shared polarity mismatch");

  // Request pin edge bits follow a write; the reserved top stays fixed
  req_sel_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_REQ_EDGE) |=>
    request_pin_edge_select_r[3:0] == $past(wbyte[3:0]) &&
    request_pin_edge_select_r[7:4] == 4'h7)
    else $error("Request pin edge select did not take write");

  // Interrupt pin edge register takes the whole byte
  int_sel_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_INT_EDGE) |=>
    int_pin_edge_select_r == $past(wbyte))
    else $error("Interrupt pin edge select did not take write");

  // Shared polarity outputs carry bits 7..5 of the written byte
  share_wr_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_INT_EDGE) |=>
    {timer_y_event_input_rise_out, timer_b1_event_input_rise_out,
     converter_trigger_input_rise_out} == $past(wbyte[7:5]))
    else $error("Shared polarity outputs wrong after write");

  // Request pin enables follow a write
  en1_pins_a: assert property (wr_en && hit(paddr_in, esie_pkg::OFF_EN1) |=>
    timer_and_irq_enable_r[3:0] == $past(wbyte[3:0]))
    else $error("Request pin enables did not take write");

  // First edge after reset release still shows the reset values
  rst_val_a: assert property ($fell(rst_in) |->
    int_pin_edge_select_r == esie_pkg::RST_INT_EDGE &&
    timer_and_irq_enable_r == esie_pkg::RST_EN1 &&
    misc_source_enable_r == esie_pkg::RST_EN2)
    else $error("Register not at reset value after reset");

  // Any interrupt pin edge leaves its flag set on the next cycle
  int_flag_a: assert property (int_edge != '0 |=>
    (int_flag_r & $past(int_edge)) == $past(int_edge))
    else $error("Interrupt pin flag not set by its edge");

  // Flags still set while the global mask is up
  mask_set_a: assert property (cpu_imask_in && serial_one_done_in |=>
    flag2_r[esie_pkg::BIT_S1])
    else $error("Flag not set while masked");

  // No group 1 or group 2 request reaches the core without both flag and enable
  fwd_need_a: assert property (
    (irq_grp1_out & ~(flag1_r & timer_and_irq_enable_r)) == 8'h00 &&
    (irq_grp2_out & ~(flag2_r & misc_source_enable_r)) == 8'h00)
    else $error("Request forwarded without flag and enable");

  // A request pin edge with its mode bit off leaves the flag clear
  pin_mode_a: assert property (req_edge[0] && !mode_r[0] && !flag1_r[0] |=>
    !flag1_r[0])
    else $error("Request pin flagged with mode off");

  // Main scenarios the bench is expected to reach

  write_cov: cover property (wr_en && hit(paddr_in, esie_pkg::OFF_EN1));
  edge_cov:  cover property (req_edge[2] && mode_r[2]);
  irq_cov:   cover property (irq_any_out);
  clr_cov:   cover property (wr_en && hit(paddr_in, esie_pkg::OFF_INT_FLAG) && |int_flag_r);
  mask_cov:  cover property (cpu_imask_in && |flag2_r);
endmodule : esie_top

/* verif/esie_cpu_model.sv */
/*
  CPU core model: owns the global mask bit and watches the request lines.
  Assumes the bench commands the mask level on clock_in.
*/
`timescale 1ns/10ps
module esie_cpu_model (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic irq_any_in,   // Any forwarded request
  input  wire logic mask_req_in,  // Bench asks for the mask
  output logic      imask_out,    // Global mask bit
  output logic      take_out      // Request accepted this cycle
);
  // Masked out of reset, so nothing is taken before the stack is set
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) imask_out <= 1'b1;
    else imask_out <= mask_req_in;
  end
  // Accept only while unmasked; flags are left for software to clear
  assign take_out = irq_any_in & ~imask_out;
endmodule : esie_cpu_model

/* verif/testbench.sv */
/*
  Testbench: APB register tasks, pin and event scenarios.
  Assumes a zero-wait APB slave and two-flop pin synchronisers.
*/
`timescale 1ns/10ps
module testbench;
  logic        clk    = 1'b0;    // 250 MHz
  logic        rst    = 1'b1;    // Async, active high
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        perr;
  logic [3:0]  rpin   = 4'hf;    // Pins idle high
  logic [7:0]  ipin   = 8'hff;
  logic [4:0]  ev     = 5'h00;   // Peripheral event pulses
  logic        mreq   = 1'b0;    // Mask request to core model
  logic        imask;
  logic        take;
  logic        ty, tb, ct;       // Shared polarity outputs
  logic [7:0]  g1, g2, gi;
  logic        gany;
  logic [31:0] rd;               // Last read data
  logic        err;              // Last error response
  int          mismatches = 0;
  int          n_tests    = 0;
  logic [7:0]  offs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  logic [7:0]  rstv [4] = '{8'h70, 8'h00, 8'h10, 8'h00};
  logic [7:0]  onev [4] = '{8'h7f, 8'hff, 8'hdf, 8'hd0};
  int          ebit [5] = '{7, 6, 7, 6, 4};

  always #2 clk = ~clk;

  esie_top u_dut (.clock_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .external_request_pin_in(rpin), .external_interrupt_pin_in(ipin),
    .timer_b1_ovf_in(ev[0]), .timer_a_ovf_in(ev[1]), .direct_transfer_in(ev[2]),
    .converter_end_in(ev[3]), .serial_one_done_in(ev[4]), .cpu_imask_in(imask),
    .timer_y_event_input_rise_out(ty), .timer_b1_event_input_rise_out(tb),
    .converter_trigger_input_rise_out(ct), .irq_grp1_out(g1), .irq_grp2_out(g2),
    .irq_int_out(gi), .irq_any_out(gany));

  esie_cpu_model u_cpu (.clock_in(clk), .rst_in(rst), .irq_any_in(gany),
    .mask_req_in(mreq), .imask_out(imask), .take_out(take));

  // Verdict and end of run
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen    <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    rd   = prdata;
    err  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rdchk

  // Pin change, then time for sync, history and flag stages
  task automatic setpin(input bit g, input int n, input logic v);
    @(posedge clk);
    if (g) ipin[n] <= v;
    else rpin[n] <= v;
    repeat (6) @(posedge clk);
  endtask : setpin

  // Selected edge sets the flag, the opposite one does not
  task automatic pin_case(input bit g, input int n, input logic pol);
    logic [7:0] eo, fo, base, bitv;
    eo   = g ? esie_pkg::OFF_INT_EDGE : esie_pkg::OFF_REQ_EDGE;
    fo   = g ? esie_pkg::OFF_INT_FLAG : esie_pkg::OFF_FLAG1;
    base = g ? 8'h00 : 8'h10;
    bitv = 8'h01 << n;
    apb(1'b1, eo, pol ? bitv : 8'h00);
    @(posedge clk);
    chk("shared pol", {ty, tb, ct}, {29'h0, g & pol & (n == 7), g & pol & (n == 6),
      g & pol & (n == 5)});
    setpin(g, n, ~pol);
    apb(1'b1, fo, 8'h00);
    setpin(g, n, pol);
    rdchk("pin flag", fo, base | bitv);
    chk("pin irq", {24'h0, g ? gi : g1}, {24'h0, bitv});
    apb(1'b1, fo, 8'h00);
    setpin(g, n, ~pol);
    rdchk("opposite edge", fo, base);
    setpin(g, n, 1'b1);
    apb(1'b1, fo, 8'h00);
  endtask : pin_case

  // Event pulse: gating by enable, by mask, and clearing by zero write
  task automatic ev_case(input int k);
    logic [7:0] eo, fo, base, bitv;
    eo   = k < 2 ? esie_pkg::OFF_EN1 : esie_pkg::OFF_EN2;
    fo   = k < 2 ? esie_pkg::OFF_FLAG1 : esie_pkg::OFF_FLAG2;
    base = k < 2 ? 8'h10 : 8'h00;
    bitv = 8'h01 << ebit[k];
    apb(1'b1, eo, 8'h00);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq disabled", {24'h0, k < 2 ? g1 : g2}, 32'h0);
    apb(1'b1, eo, bitv);
    @(posedge clk);
    chk("irq enabled", {24'h0, k < 2 ? g1 : g2}, {24'h0, bitv});
    chk("irq any", {31'h0, gany}, 32'h1);
    chk("taken", {31'h0, take}, 32'h1);
    @(posedge clk);
    mreq <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq masked", {24'h0, k < 2 ? g1 : g2}, 32'h0);
    chk("not taken", {31'h0, take}, 32'h0);
    apb(1'b1, fo, 8'hff);
    rdchk("flag kept", fo, base | bitv);
    apb(1'b1, fo, 8'h00);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    rdchk("set while masked", fo, base | bitv);
    @(posedge clk);
    mreq <= 1'b0;
    apb(1'b1, fo, 8'h00);
    rdchk("flag cleared", fo, base);
  endtask : ev_case

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdchk("reset value", offs[i], rstv[i]);
      apb(1'b1, offs[i], 8'hff);
      rdchk("all ones", offs[i], onev[i]);
      apb(1'b1, offs[i], 8'h00);
      rdchk("all zeros", offs[i], rstv[i]);
    end
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, esie_pkg::OFF_MODE, 8'h0f);
    apb(1'b1, esie_pkg::OFF_EN1, 8'h0f);
    apb(1'b1, esie_pkg::OFF_INT_EN, 8'hff);
    for (int n = 0; n < 4; n++) begin
      pin_case(1'b0, n, 1'b0);
      pin_case(1'b0, n, 1'b1);
    end
    for (int n = 0; n < 8; n++) begin
      pin_case(1'b1, n, 1'b0);
      pin_case(1'b1, n, 1'b1);
    end
    apb(1'b1, esie_pkg::OFF_MODE, 8'h00);
    setpin(1'b0, 0, 1'b0);
    rdchk("pin mode off", esie_pkg::OFF_FLAG1, 8'h10);
    setpin(1'b0, 0, 1'b1);
    apb(1'b1, esie_pkg::OFF_INT_EN, 8'h00);
    for (int k = 0; k < 5; k++) ev_case(k);
    print_verdict();
  end
endmodule : testbench
